// File: core/isrm_pkg.sv
// Constants, types and decoders shared by the I/O slot remapper
// Behaviour
// RULE1: Remapping is off after reset until the enable parameter is set.
// RULE2: Table holds 64 bytes; byte n is target slot n+1; record 0x7F.
// RULE3: Entry zero makes its target slot a gap with no module.
// RULE4: Entry 1..64 routes every access to that actual slot.
// RULE5: Entry 255 marks the target slot as a virtual module.
// RULE6: Reads of a virtual module always return zero.
// RULE7: Writes to a virtual module are dropped; nothing is driven.
// RULE8: Host always writes the whole 64-byte table at once.
// RULE9: Table reads may fetch any part of the active table.
// RULE10: A valid table is stored only when it differs from the held one.
// RULE11: Committed table goes to retentive storage and returns at start-up.
// RULE12: A committed table is active at once for later accesses.
// RULE13: Enabled, valid remapping reports no start-up mismatch.
// RULE14: Any slot order is allowed; installed slots may be deactivated.
// RULE15: Host sends the record to the controller's diagnostic address.
// RULE16: Configurer also enables start despite mismatch.
// RULE17: Mismatch without that option keeps the controller stopped.
// RULE18: Tables with any undefined entry are rejected; old table stays.
// RULE19: With remapping off every slot maps to itself.
package isrm_pkg;
   localparam int         SLOTS     = 64;
   localparam int         IMG_W     = 512;
   localparam int         ADDR_W    = 16;
   localparam logic [6:0] CNT_ZERO  = 7'h00;
   localparam logic [6:0] CNT_FULL  = 7'h40;
   localparam logic [7:0] REC_MAP   = 8'h7F;
   localparam logic [7:0] ENT_GAP   = 8'h00;
   localparam logic [7:0] ENT_LO    = 8'h01;
   localparam logic [7:0] ENT_HI    = 8'h40;
   localparam logic [7:0] ENT_VIRT  = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [6:0] SLOT_LO   = 7'h01;
   localparam logic [6:0] SLOT_HI   = 7'h40;

   typedef enum logic [1:0] {ISRM_GAP, ISRM_ROUTE, ISRM_VIRT} isrm_kind_t;
   typedef enum logic {WS_COLLECT, WS_EVAL} isrm_wst_t;
   typedef enum logic {AS_IDLE, AS_WAIT} isrm_ast_t;

   function automatic logic isrm_ent_ok(input logic [7:0] e);
      return (e == ENT_GAP) || (e == ENT_VIRT) || (e >= ENT_LO && e <= ENT_HI);
   endfunction

   function automatic logic isrm_slot_ok(input logic [6:0] s);
      return (s >= SLOT_LO) && (s <= SLOT_HI);
   endfunction

   function automatic logic [5:0] isrm_idx(input logic [6:0] s);
      logic [6:0] d;
      d = s - SLOT_LO;
      return d[5:0];
   endfunction

   function automatic logic [7:0] isrm_pick(input logic [IMG_W-1:0] img, input logic [5:0] i);
      return img[{i, 3'b000} +: 8];
   endfunction

   function automatic isrm_kind_t isrm_kind(input logic en, input logic [6:0] s, input logic [7:0] e);
      if (!isrm_slot_ok(s))
         return ISRM_GAP;
      if (!en)
         return ISRM_ROUTE;
      if (e == ENT_VIRT)
         return ISRM_VIRT;
      if (e >= ENT_LO && e <= ENT_HI)
         return ISRM_ROUTE;
      return ISRM_GAP;
   endfunction
endpackage

// File: core/isrm_stage.sv
// Staging buffer that collects and checks one written table record
module isrm_stage (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire logic                      byte_valid,
   input  wire logic                      byte_first,
   input  wire logic                      byte_reject,
   input  wire logic [7:0]                byte_data,
   output logic      [6:0]                count,
   output logic                           bad,
   output logic      [isrm_pkg::IMG_W-1:0] image
);
   logic [7:0] buf_r   [isrm_pkg::SLOTS];
   logic [7:0] buf_nxt [isrm_pkg::SLOTS];
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic       bad_r;
   logic       bad_nxt;

   always_comb
   begin
      buf_nxt = buf_r;
      cnt_nxt = cnt_r;
      bad_nxt = bad_r;
      if (byte_valid)
      begin
         cnt_nxt = byte_first ? isrm_pkg::CNT_ZERO : cnt_r;
         // Overlong or malformed records poison the whole table
         bad_nxt = (byte_first ? 1'b0 : bad_r) | byte_reject | !isrm_pkg::isrm_ent_ok(byte_data) //RULE18
                   | (cnt_nxt == isrm_pkg::CNT_FULL); //RULE8
         if (cnt_nxt != isrm_pkg::CNT_FULL)
         begin
            buf_nxt[cnt_nxt[5:0]] = byte_data; //RULE2
            cnt_nxt = cnt_nxt + 7'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         buf_r <= '{default: isrm_pkg::ENT_GAP};
         cnt_r <= isrm_pkg::CNT_ZERO;
         bad_r <= 1'b1;
      end
      else
      begin
         buf_r <= buf_nxt;
         cnt_r <= cnt_nxt;
         bad_r <= bad_nxt;
      end
   end

   always_comb
   begin
      for (int n = 0; n < isrm_pkg::SLOTS; n++)
         image[n*8 +: 8] = buf_r[n];
   end

   assign count = cnt_r;
   assign bad   = bad_r;
endmodule

// File: core/isrm_table.sv
// Active mapping table with retentive restore and commit
module isrm_table (
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   input  wire logic                       restore_valid,
   input  wire logic [isrm_pkg::IMG_W-1:0] restore_data,
   input  wire logic                       commit,
   input  wire logic [isrm_pkg::IMG_W-1:0] commit_data,
   output logic      [isrm_pkg::IMG_W-1:0] image
);
   logic [7:0] tab_r   [isrm_pkg::SLOTS];
   logic [7:0] tab_nxt [isrm_pkg::SLOTS];

   always_comb
   begin
      tab_nxt = tab_r;
      for (int n = 0; n < isrm_pkg::SLOTS; n++)
      begin
         // A fresh commit must not be overwritten by a late restore
         if (commit)
            tab_nxt[n] = commit_data[n*8 +: 8]; //RULE12
         else if (restore_valid)
            tab_nxt[n] = restore_data[n*8 +: 8]; //RULE11
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Identity table so enabling before any write changes nothing
         for (int n = 0; n < isrm_pkg::SLOTS; n++)
            tab_r[n] <= 8'(n + 1);
      end
      else
         tab_r <= tab_nxt;
   end

   always_comb
   begin
      for (int n = 0; n < isrm_pkg::SLOTS; n++)
         image[n*8 +: 8] = tab_r[n];
   end
endmodule

// File: core/isrm_top.sv
// I/O slot remapper: record access, slot routing and start-up check
module isrm_top (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        cfg_remap_en,
   input  wire logic                        cfg_start_on_mismatch,
   input  wire logic [isrm_pkg::ADDR_W-1:0] cfg_diag_addr,
   input  wire logic                        wr_valid,
   input  wire logic                        wr_first,
   input  wire logic                        wr_last,
   input  wire logic [7:0]                  wr_rec,
   input  wire logic [isrm_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [7:0]                  wr_data,
   output logic                             wr_done,
   output logic                             wr_err,
   output logic                             wr_stored,
   input  wire logic                        rd_req,
   input  wire logic [7:0]                  rd_rec,
   input  wire logic [isrm_pkg::ADDR_W-1:0] rd_addr,
   input  wire logic [5:0]                  rd_byte,
   output logic                             rd_valid,
   output logic                             rd_err,
   output logic      [7:0]                  rd_data,
   input  wire logic                        nv_restore_valid,
   input  wire logic [isrm_pkg::IMG_W-1:0]  nv_restore_data,
   output logic                             nv_store,
   output logic      [isrm_pkg::IMG_W-1:0]  nv_store_data,
   input  wire logic                        acc_req,
   input  wire logic                        acc_write,
   input  wire logic [6:0]                  acc_slot,
   input  wire logic [7:0]                  acc_wdata,
   output logic                             acc_done,
   output logic                             acc_gap,
   output logic      [7:0]                  acc_rdata,
   output logic                             bp_req,
   output logic                             bp_write,
   output logic      [6:0]                  bp_slot,
   output logic      [7:0]                  bp_wdata,
   input  wire logic                        bp_done,
   input  wire logic [7:0]                  bp_rdata,
   input  wire logic [isrm_pkg::SLOTS-1:0]  slot_used,
   input  wire logic [isrm_pkg::SLOTS-1:0]  slot_installed,
   output logic                             cfg_mismatch,
   input  wire logic                        run_req,
   output logic                             run_state
);
   logic                       rst_s1_r;
   logic                       rst_s2_r;
   logic                       rsn;
   logic [6:0]                 stg_count;
   logic                       stg_bad;
   logic [isrm_pkg::IMG_W-1:0] stg_img;
   logic [isrm_pkg::IMG_W-1:0] tab_img;
   logic                       wr_reject;
   logic                       eval_ok;
   logic                       eval_diff;
   logic                       commit;
   isrm_pkg::isrm_wst_t        wst_r;
   isrm_pkg::isrm_wst_t        wst_nxt;
   logic                       wr_done_r;
   logic                       wr_done_nxt;
   logic                       wr_err_r;
   logic                       wr_err_nxt;
   logic                       wr_stored_r;
   logic                       wr_stored_nxt;
   logic                       rd_valid_r;
   logic                       rd_valid_nxt;
   logic                       rd_err_r;
   logic                       rd_err_nxt;
   logic [7:0]                 rd_data_r;
   logic [7:0]                 rd_data_nxt;
   logic [7:0]                 acc_ent;
   isrm_pkg::isrm_kind_t       acc_kind;
   logic [6:0]                 acc_dest;
   isrm_pkg::isrm_ast_t        ast_r;
   isrm_pkg::isrm_ast_t        ast_nxt;
   logic                       acc_done_r;
   logic                       acc_done_nxt;
   logic                       acc_gap_r;
   logic                       acc_gap_nxt;
   logic [7:0]                 acc_rdata_r;
   logic [7:0]                 acc_rdata_nxt;
   logic                       bp_req_r;
   logic                       bp_req_nxt;
   logic                       bp_write_r;
   logic                       bp_write_nxt;
   logic [6:0]                 bp_slot_r;
   logic [6:0]                 bp_slot_nxt;
   logic [7:0]                 bp_wdata_r;
   logic [7:0]                 bp_wdata_nxt;
   logic [7:0]                 chk_ent;
   logic                       mis_nxt;
   logic                       mis_r;
   logic                       run_nxt;
   logic                       run_r;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end
   assign rsn = rst_s2_r;

   // Record must target the mapping record at our diagnostic address
   assign wr_reject = (wr_rec != isrm_pkg::REC_MAP) || (wr_addr != cfg_diag_addr); //RULE15

   isrm_stage u_stage (
      .clock       (clock),
      .rst_n       (rsn),
      .byte_valid  (wr_valid),
      .byte_first  (wr_first),
      .byte_reject (wr_reject),
      .byte_data   (wr_data),
      .count       (stg_count),
      .bad         (stg_bad),
      .image       (stg_img)
   );

   isrm_table u_table (
      .clock         (clock),
      .rst_n         (rsn),
      .restore_valid (nv_restore_valid),
      .restore_data  (nv_restore_data),
      .commit        (commit),
      .commit_data   (stg_img),
      .image         (tab_img)
   );

   // Partial records never reach the table
   assign eval_ok   = (stg_count == isrm_pkg::CNT_FULL) && !stg_bad; //RULE8 RULE18
   assign eval_diff = stg_img != tab_img;
   assign commit    = (wst_r == isrm_pkg::WS_EVAL) && eval_ok && eval_diff; //RULE10

   always_comb
   begin
      wst_nxt       = wst_r;
      wr_done_nxt   = 1'b0;
      wr_err_nxt    = 1'b0;
      wr_stored_nxt = 1'b0;
      case (wst_r)
         isrm_pkg::WS_COLLECT:
         begin
            if (wr_valid && wr_last)
               wst_nxt = isrm_pkg::WS_EVAL;
         end
         isrm_pkg::WS_EVAL:
         begin
            wst_nxt       = isrm_pkg::WS_COLLECT;
            wr_done_nxt   = eval_ok;
            wr_err_nxt    = !eval_ok; //RULE18
            wr_stored_nxt = commit; //RULE11
         end
         default:
            wst_nxt = isrm_pkg::WS_COLLECT;
      endcase
   end

   always_ff @(posedge clock or negedge rsn)
   begin
      if (!rsn)
      begin
         wst_r       <= isrm_pkg::WS_COLLECT;
         wr_done_r   <= 1'b0;
         wr_err_r    <= 1'b0;
         wr_stored_r <= 1'b0;
      end
      else
      begin
         wst_r       <= wst_nxt;
         wr_done_r   <= wr_done_nxt;
         wr_err_r    <= wr_err_nxt;
         wr_stored_r <= wr_stored_nxt;
      end
   end

   always_comb
   begin
      rd_valid_nxt = rd_req;
      rd_err_nxt   = 1'b0;
      rd_data_nxt  = isrm_pkg::ZERO_BYTE;
      if (rd_req)
      begin
         if ((rd_rec == isrm_pkg::REC_MAP) && (rd_addr == cfg_diag_addr))
            rd_data_nxt = isrm_pkg::isrm_pick(tab_img, rd_byte); //RULE9
         else
            rd_err_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rsn)
   begin
      if (!rsn)
      begin
         rd_valid_r <= 1'b0;
         rd_err_r   <= 1'b0;
         rd_data_r  <= isrm_pkg::ZERO_BYTE;
      end
      else
      begin
         rd_valid_r <= rd_valid_nxt;
         rd_err_r   <= rd_err_nxt;
         rd_data_r  <= rd_data_nxt;
      end
   end

   assign acc_ent  = isrm_pkg::isrm_pick(tab_img, isrm_pkg::isrm_idx(acc_slot));
   assign acc_kind = isrm_pkg::isrm_kind(cfg_remap_en, acc_slot, acc_ent); //RULE1 RULE3 RULE5 RULE14
   assign acc_dest = cfg_remap_en ? acc_ent[6:0] : acc_slot; //RULE4 RULE19

   always_comb
   begin
      ast_nxt       = ast_r;
      acc_done_nxt  = 1'b0;
      acc_gap_nxt   = 1'b0;
      acc_rdata_nxt = acc_rdata_r;
      bp_req_nxt    = bp_req_r;
      bp_write_nxt  = bp_write_r;
      bp_slot_nxt   = bp_slot_r;
      bp_wdata_nxt  = bp_wdata_r;
      case (ast_r)
         isrm_pkg::AS_IDLE:
         begin
            if (acc_req)
            begin
               case (acc_kind)
                  isrm_pkg::ISRM_ROUTE:
                  begin
                     ast_nxt      = isrm_pkg::AS_WAIT;
                     bp_req_nxt   = 1'b1;
                     bp_write_nxt = acc_write;
                     bp_slot_nxt  = acc_dest; //RULE4
                     bp_wdata_nxt = acc_wdata;
                  end
                  isrm_pkg::ISRM_VIRT:
                  begin
                     // Answered locally; the backplane never sees it
                     acc_done_nxt  = 1'b1; //RULE7
                     acc_rdata_nxt = isrm_pkg::ZERO_BYTE; //RULE6
                  end
                  default:
                  begin
                     acc_done_nxt  = 1'b1;
                     acc_gap_nxt   = 1'b1; //RULE3
                     acc_rdata_nxt = isrm_pkg::ZERO_BYTE;
                  end
               endcase
            end
         end
         isrm_pkg::AS_WAIT:
         begin
            if (bp_done)
            begin
               ast_nxt       = isrm_pkg::AS_IDLE;
               bp_req_nxt    = 1'b0;
               acc_done_nxt  = 1'b1;
               acc_rdata_nxt = bp_write_r ? isrm_pkg::ZERO_BYTE : bp_rdata;
            end
         end
         default:
         begin
            ast_nxt    = isrm_pkg::AS_IDLE;
            bp_req_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rsn)
   begin
      if (!rsn)
      begin
         ast_r       <= isrm_pkg::AS_IDLE;
         acc_done_r  <= 1'b0;
         acc_gap_r   <= 1'b0;
         acc_rdata_r <= isrm_pkg::ZERO_BYTE;
         bp_req_r    <= 1'b0;
         bp_write_r  <= 1'b0;
         bp_slot_r   <= isrm_pkg::CNT_ZERO;
         bp_wdata_r  <= isrm_pkg::ZERO_BYTE;
      end
      else
      begin
         ast_r       <= ast_nxt;
         acc_done_r  <= acc_done_nxt;
         acc_gap_r   <= acc_gap_nxt;
         acc_rdata_r <= acc_rdata_nxt;
         bp_req_r    <= bp_req_nxt;
         bp_write_r  <= bp_write_nxt;
         bp_slot_r   <= bp_slot_nxt;
         bp_wdata_r  <= bp_wdata_nxt;
      end
   end

   // Gaps and virtual modules are expected absences, not mismatches
   always_comb
   begin
      mis_nxt = 1'b0;
      chk_ent = isrm_pkg::ENT_GAP;
      for (int n = 0; n < isrm_pkg::SLOTS; n++)
      begin
         chk_ent = tab_img[n*8 +: 8];
         if (slot_used[n])
         begin
            if (!cfg_remap_en)
               mis_nxt = mis_nxt | !slot_installed[n];
            else if (chk_ent >= isrm_pkg::ENT_LO && chk_ent <= isrm_pkg::ENT_HI)
               mis_nxt = mis_nxt | !slot_installed[isrm_pkg::isrm_idx(chk_ent[6:0])]; //RULE13
         end
      end
      // Only entry to run is gated; a later mismatch does not stop it
      run_nxt = run_req && (run_r || !mis_r || cfg_start_on_mismatch); //RULE17
   end

   always_ff @(posedge clock or negedge rsn)
   begin
      if (!rsn)
      begin
         mis_r <= 1'b0;
         run_r <= 1'b0;
      end
      else
      begin
         mis_r <= mis_nxt;
         run_r <= run_nxt;
      end
   end

   assign wr_done       = wr_done_r;
   assign wr_err        = wr_err_r;
   assign wr_stored     = wr_stored_r;
   assign nv_store      = wr_stored_r; //RULE11
   assign nv_store_data = tab_img;
   assign rd_valid      = rd_valid_r;
   assign rd_err        = rd_err_r;
   assign rd_data       = rd_data_r;
   assign acc_done      = acc_done_r;
   assign acc_gap       = acc_gap_r;
   assign acc_rdata     = acc_rdata_r;
   assign bp_req        = bp_req_r;
   assign bp_write      = bp_write_r;
   assign bp_slot       = bp_slot_r;
   assign bp_wdata      = bp_wdata_r;
   assign cfg_mismatch  = mis_r;
   assign run_state     = run_r;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rsn);

   sequence s_new(isrm_pkg::isrm_kind_t k);
      (ast_r == isrm_pkg::AS_IDLE) && acc_req && (acc_kind == k);
   endsequence
   sequence s_eval;
      wst_r == isrm_pkg::WS_EVAL;
   endsequence

   property p_virt_zero;
      s_new(isrm_pkg::ISRM_VIRT) |=> acc_done && !acc_gap && (acc_rdata == isrm_pkg::ZERO_BYTE);
   endproperty
   a_virt_zero: assert property (p_virt_zero) else $error("virtual read not zero"); //RULE6
   property p_virt_quiet;
      s_new(isrm_pkg::ISRM_VIRT) |=> !bp_req ##1 !bp_req;
   endproperty
   a_virt_quiet: assert property (p_virt_quiet) else $error("virtual access reached backplane"); //RULE7
   property p_gap;
      s_new(isrm_pkg::ISRM_GAP) |=> acc_done && acc_gap && !bp_req;
   endproperty
   a_gap: assert property (p_gap) else $error("gap slot not ignored"); //RULE3
   property p_route;
      s_new(isrm_pkg::ISRM_ROUTE) |=> bp_req && (!$past(cfg_remap_en) || (bp_slot == $past(acc_ent[6:0])));
   endproperty
   a_route: assert property (p_route) else $error("routed to wrong slot"); //RULE4
   property p_direct;
      (ast_r == isrm_pkg::AS_IDLE) && acc_req && !cfg_remap_en && isrm_pkg::isrm_slot_ok(acc_slot)
         |=> bp_req && (bp_slot == $past(acc_slot));
   endproperty
   a_direct: assert property (p_direct) else $error("disabled remap not direct"); //RULE19
   property p_same_nostore;
      s_eval and (stg_img == tab_img) |=> !nv_store && !wr_stored;
   endproperty
   a_same_nostore: assert property (p_same_nostore) else $error("identical table stored"); //RULE10
   property p_store;
      s_eval and eval_ok and eval_diff |=> nv_store && wr_done && (nv_store_data == $past(stg_img));
   endproperty
   a_store: assert property (p_store) else $error("valid table not stored"); //RULE12
   property p_invalid;
      s_eval and !eval_ok and !nv_restore_valid |=> wr_err && !nv_store && $stable(tab_img);
   endproperty
   a_invalid: assert property (p_invalid) else $error("invalid table accepted"); //RULE18
   property p_read;
      rd_req && (rd_rec == isrm_pkg::REC_MAP) && (rd_addr == cfg_diag_addr)
         |=> rd_valid && !rd_err && (rd_data == $past(isrm_pkg::isrm_pick(tab_img, rd_byte)));
   endproperty
   a_read: assert property (p_read) else $error("table read wrong"); //RULE9
   property p_stop;
      !run_state && mis_r && !cfg_start_on_mismatch |=> !run_state;
   endproperty
   a_stop: assert property (p_stop) else $error("run entered despite mismatch"); //RULE17
endmodule

// File: testbench/isrm_bp_model.sv
// Backplane I/O module stand-in answering routed slot accesses
module isrm_bp_model (
   input  wire logic       clock,
   input  wire logic       bp_req,
   input  wire logic [6:0] bp_slot,
   output logic            bp_done,
   output logic      [7:0] bp_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_r = 2'h0;
   logic       hit;
   initial bp_done = 1'b0;
   initial bp_rdata = 8'h00;
   assign hit = bp_req && !bp_done && (wait_r == 2'h2);
   // Answers after a few cycles; data toggles when not valid so stale bytes never match
   always @(posedge clock)
   begin
      wait_r <= (bp_req && !bp_done) ? wait_r + 2'h1 : 2'h0;
      bp_done <= hit;
      bp_rdata <= hit ? {1'b1, bp_slot} : ~bp_rdata;
   end
endmodule

// File: testbench/isrm_top_tb.sv
// Self-checking bench for the I/O slot remapper
module isrm_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] DIAG = 16'h1234;
   logic        clock = 1'b0, rst_n = 1'b0, cfg_remap_en = 1'b0, cfg_start_on_mismatch = 1'b0;
   logic        wr_valid = 1'b0, wr_first = 1'b0, wr_last = 1'b0, rd_req = 1'b0;
   logic        acc_req = 1'b0, acc_write = 1'b0, run_req = 1'b0, nv_restore_valid = 1'b0;
   logic [511:0] nv_restore_data = 512'h0, img;
   logic [8:0]  w;
   logic [7:0]  wr_data = 8'h00, wr_rec = 8'h7F, rd_rec = 8'h7F, acc_wdata = 8'h00;
   logic [5:0]  rd_byte = 6'h00;
   logic [6:0]  acc_slot = 7'h01;
   logic [63:0] slot_used = 64'h0, slot_installed = 64'h0;
   logic [7:0]  t [64];
   logic [7:0]  r, s;
   logic [2:0]  res;
   logic [9:0]  v;
   int          fail_count = 0, checks = 0;
   wire         wr_done, wr_err, wr_stored, rd_valid, rd_err, nv_store, acc_done, acc_gap;
   wire         bp_req, bp_write, bp_done, cfg_mismatch, run_state;
   wire [7:0]   rd_data, acc_rdata, bp_wdata, bp_rdata;
   wire [6:0]   bp_slot;
   wire [511:0] nv_store_data;

   isrm_top i_isrm_top (.clock, .rst_n, .cfg_remap_en, .cfg_start_on_mismatch, .cfg_diag_addr(DIAG),
      .wr_valid, .wr_first, .wr_last, .wr_rec, .wr_addr(DIAG), .wr_data, .wr_done, .wr_err, .wr_stored,
      .rd_req, .rd_rec, .rd_addr(DIAG), .rd_byte, .rd_valid, .rd_err, .rd_data,
      .nv_restore_valid, .nv_restore_data, .nv_store, .nv_store_data,
      .acc_req, .acc_write, .acc_slot, .acc_wdata, .acc_done, .acc_gap, .acc_rdata,
      .bp_req, .bp_write, .bp_slot, .bp_wdata, .bp_done, .bp_rdata,
      .slot_used, .slot_installed, .cfg_mismatch, .run_req, .run_state);
   isrm_bp_model i_isrm_bp_model (.clock, .bp_req, .bp_slot, .bp_done, .bp_rdata);

   initial
   begin
      forever #20 clock = ~clock;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Whole record streamed byte by byte; result is {done, err, stored}
   task automatic wr_tbl;
      int n;
      for (int i = 0; i < 64; i++)
      begin
         @(negedge clock);
         wr_valid = 1'b1;
         wr_first = (i == 0);
         wr_last = (i == 63);
         wr_data = t[i];
      end
      @(negedge clock);
      wr_valid = 1'b0;
      wr_last = 1'b0;
      res = 3'b000;
      n = 0;
      while (res == 3'b000 && n < 8)
      begin
         @(negedge clock);
         res = {wr_done, wr_err, wr_stored};
         n++;
      end
   endtask

   // s: backplane slot seen (0 = none, 80 = gap)
   task automatic acc(input logic [6:0] sl, input logic wr);
      int n;
      @(negedge clock);
      acc_req = 1'b1;
      acc_slot = sl;
      acc_write = wr;
      @(negedge clock);
      acc_req = 1'b0;
      s = 8'h00;
      n = 0;
      while (acc_done !== 1'b1 && n < 20)
      begin
         if (bp_req === 1'b1)
         begin
            s = {1'b0, bp_slot};
            w = {bp_write, bp_wdata};
         end
         @(negedge clock);
         n++;
      end
      r = acc_rdata;
      if (acc_gap === 1'b1)
         s = 8'h80;
      chk(acc_done, 1'b1);
   endtask

   task automatic rd(input logic [5:0] b);
      @(negedge clock);
      rd_req = 1'b1;
      rd_byte = b;
      @(negedge clock);
      rd_req = 1'b0;
      v = {rd_valid, rd_err, rd_data};
   endtask

   initial
   begin
      #80000;
      fail_count++;
      final_report;
   end

   initial
   begin
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      acc(7'h05, 1'b0);
      chk(s, 8'h05);
      chk(r, 8'h85);
      for (int i = 0; i < 64; i++)
         t[i] = 8'h40 - 8'(i);
      t[1] = 8'hFF;
      t[2] = 8'h00;
      wr_tbl;
      chk(res, 3'b101);
      chk(nv_store_data[23:0], 24'h00FF40);
      acc(7'h05, 1'b0);
      chk(s, 8'h05);
      cfg_remap_en = 1'b1;
      acc(7'h01, 1'b0);
      chk(s, 8'h40);
      chk(r, 8'hC0);
      acc(7'h02, 1'b0);
      chk({s, r}, 16'h0000);
      acc(7'h02, 1'b1);
      chk(s, 8'h00);
      acc(7'h03, 1'b0);
      chk(s, 8'h80);
      acc_wdata = 8'h5A;
      acc(7'h01, 1'b1);
      chk({s, r}, 16'h4000);
      chk(w, 9'h15A);
      wr_tbl;
      chk(res, 3'b100);
      t[0] = 8'h41;
      wr_tbl;
      chk(res, 3'b010);
      rd(6'h00);
      chk(v, 10'h240);
      rd(6'h3F);
      chk(v, 10'h201);
      rd_rec = 8'h7E;
      rd(6'h00);
      chk(v[8:0], 9'h100);
      slot_used = 64'h1;
      slot_installed = 64'h8000000000000000;
      repeat (2) @(negedge clock);
      chk(cfg_mismatch, 1'b0);
      cfg_remap_en = 1'b0;
      // Mismatch flag lags a cycle, so let it settle before asking for run
      repeat (2) @(negedge clock);
      run_req = 1'b1;
      repeat (4) @(negedge clock);
      chk({cfg_mismatch, run_state}, 2'b10);
      cfg_start_on_mismatch = 1'b1;
      repeat (3) @(negedge clock);
      chk(run_state, 1'b1);
      img = nv_store_data;
      rst_n = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
      repeat (3) @(negedge clock);
      rd_rec = 8'h7F;
      rd(6'h01);
      chk(v, 10'h202);
      @(negedge clock);
      nv_restore_data = img;
      nv_restore_valid = 1'b1;
      @(negedge clock);
      nv_restore_valid = 1'b0;
      rd(6'h01);
      chk(v, 10'h2FF);
      final_report;
   end
endmodule
